// File: verilog/elcs_event_log.v
// Event log store with legacy cursor, message text area and status words on AHB-Lite
//
// Function
// - Three read-only event counters, all/alarm-warning/alarm.
// - Writing 0 to all-command rewinds cursor.
// - Writing 1 advances cursor to next event of its class.
// - Valid event loads text, nulls after it.
// - No further event clears whole text area.
// - Severity register shows invalid code past end.
// - All command registers share one cursor.
// - After restart or erase, reset required first.
// - Counters need not change on new event.
// - Six 16-bit status words, system then module.
// - System words only with system cabinet present.
// - Status bit meaning is revision configuration.
// - Circular store of 4096, oldest overwritten.
// - Text carries 80 characters plus null.
// - Text changes only on command writes.
`timescale 1ns/1ns
`default_nettype none
`include "elcs_regs.vh"

module elcs_event_log #(
    parameter DEPTH_LOG2 = 12,
    parameter HAS_SYS_CABINET = 1,
    parameter [15:0] SYS_STATUS_MASK = 16'hffff,
    parameter [15:0] MOD_STATUS_MASK = 16'hffff
) (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // AHB-Lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    // Event byte stream from the logging logic
    input wire evt_byte_valid,
    input wire [7:0] evt_byte,
    input wire evt_last,
    input wire [1:0] evt_severity,
    // Pins
    input wire log_erase_pin,
    input wire [47:0] sys_status_pins,
    input wire [47:0] mod_status_pins,
    // Interrupt
    output reg irq
);

    localparam DEPTH = 1 << DEPTH_LOG2;
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_SCAN = 3'b010;
    localparam [2:0] ST_COPY = 3'b100;

    // Storage
    reg [7:0] text_mem [0:DEPTH*128-1];
    reg [1:0] sev_mem [0:DEPTH-1];
    reg [6:0] len_mem [0:DEPTH-1];
    reg [7:0] text_area [0:81];

    // Store bookkeeping
    reg [15:0] wr_seq;
    reg [DEPTH_LOG2:0] fill;
    reg [6:0] wr_byte;
    reg [15:0] cnt_all;
    reg [15:0] cnt_aw;
    reg [15:0] cnt_al;

    // Cursor engine
    reg [2:0] state;
    reg [1:0] cmd_class;
    reg [15:0] cursor;
    reg cur_valid;
    reg [15:0] scan_seq;
    reg [6:0] copy_idx;
    reg [15:0] severity;

    // Bus data phase
    reg wr_pend;
    reg [9:0] wr_idx;

    // Interrupts
    reg [2:0] int_status;
    reg [2:0] int_enable;

    // Synchronisers
    reg erase_s1;
    reg erase_s2;
    reg erase_s3;
    reg [47:0] sys_s1;
    reg [47:0] sys_s2;
    reg [47:0] mod_s1;
    reg [47:0] mod_s2;

    // Read path, settled before each address phase is taken
    reg [31:0] next_rdata;
    reg [9:0] txt_off;

    wire [DEPTH_LOG2-1:0] wr_slot = wr_seq[DEPTH_LOG2-1:0];
    wire [DEPTH_LOG2-1:0] scan_slot = scan_seq[DEPTH_LOG2-1:0];
    wire [DEPTH_LOG2-1:0] cur_slot = cursor[DEPTH_LOG2-1:0];
    wire [15:0] fill16 = {{(15-DEPTH_LOG2){1'b0}}, fill};
    wire [15:0] oldest = wr_seq - fill16;
    // Fill reaches its top bit only when every slot holds an event
    wire store_full = fill[DEPTH_LOG2];
    wire commit = evt_byte_valid && evt_last;
    wire erase_evt = erase_s2 && !erase_s3;
    wire [1:0] old_sev = sev_mem[wr_slot];
    wire [1:0] scan_sev = sev_mem[scan_slot];
    wire [6:0] cur_len = len_mem[cur_slot];
    wire cmd_hit = wr_pend && (wr_idx >= `ELCS_IDX_ALL_CMD) && (wr_idx <= `ELCS_IDX_AL_CMD);
    wire cmd_reset = (hwdata[15:0] == `ELCS_CMD_RESET);
    wire cmd_adv = (hwdata[15:0] == `ELCS_CMD_ADVANCE);
    wire [9:0] cmd_off = wr_idx - `ELCS_IDX_ALL_CMD;
    wire cur_lost = ((cursor - oldest) >= fill16);
    wire end_hit = (state == ST_SCAN) && ((scan_seq == wr_seq) || erase_s2);

    function class_match;
        input [1:0] sev;
        input [1:0] cls;
        begin
            case (cls)
                `ELCS_CLASS_AW: class_match = (sev == `ELCS_SEV_NOTICE) || (sev == `ELCS_SEV_ALARM);
                `ELCS_CLASS_AL: class_match = (sev == `ELCS_SEV_ALARM);
                default: class_match = 1'b1;
            endcase
        end
    endfunction

    // Pin synchronisers
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            erase_s1 <= 1'b0;
            erase_s2 <= 1'b0;
            erase_s3 <= 1'b0;
            sys_s1 <= 48'h0;
            sys_s2 <= 48'h0;
            mod_s1 <= 48'h0;
            mod_s2 <= 48'h0;
        end
        else
        begin
            erase_s1 <= log_erase_pin;
            erase_s2 <= erase_s1;
            erase_s3 <= erase_s2;
            sys_s1 <= sys_status_pins;
            sys_s2 <= sys_s1;
            mod_s1 <= mod_status_pins;
            mod_s2 <= mod_s1;
        end
    end

    // Event memories; bytes past the character limit are dropped
    always @(posedge hclk)
    begin
        if (evt_byte_valid && (wr_byte < `ELCS_MSG_CHARS))
            text_mem[{wr_slot, wr_byte}] <= evt_byte;
        if (commit)
        begin
            sev_mem[wr_slot] <= evt_severity;
            len_mem[wr_slot] <= (wr_byte < `ELCS_MSG_CHARS) ? wr_byte + 7'h01 : wr_byte;
        end
    end

    // Circular store bookkeeping and counters
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_seq <= `ELCS_RST_WORD;
            fill <= {(DEPTH_LOG2+1){1'b0}};
            wr_byte <= 7'h00;
            cnt_all <= `ELCS_RST_WORD;
            cnt_aw <= `ELCS_RST_WORD;
            cnt_al <= `ELCS_RST_WORD;
        end
        // A held erase pin keeps the store empty
        else if (erase_s2)
        begin
            wr_seq <= `ELCS_RST_WORD;
            fill <= {(DEPTH_LOG2+1){1'b0}};
            wr_byte <= 7'h00;
            cnt_all <= `ELCS_RST_WORD;
            cnt_aw <= `ELCS_RST_WORD;
            cnt_al <= `ELCS_RST_WORD;
        end
        else if (evt_byte_valid)
        begin
            if (!commit)
                wr_byte <= (wr_byte < `ELCS_MSG_CHARS) ? wr_byte + 7'h01 : wr_byte;
            else
            begin
                wr_byte <= 7'h00;
                wr_seq <= wr_seq + 16'h0001;
                // Full store overwrites the oldest entry, so its class leaves the counts
                if (!store_full)
                begin
                    fill <= fill + 1'b1;
                    cnt_all <= cnt_all + 16'h0001;
                end
                cnt_aw <= cnt_aw + {15'h0, class_match(evt_severity, `ELCS_CLASS_AW)}
                    - {15'h0, store_full && class_match(old_sev, `ELCS_CLASS_AW)};
                cnt_al <= cnt_al + {15'h0, class_match(evt_severity, `ELCS_CLASS_AL)}
                    - {15'h0, store_full && class_match(old_sev, `ELCS_CLASS_AL)};
            end
        end
    end

    // Bus slave and cursor engine
    always @(posedge hclk or negedge hresetn)
    begin : engine
        integer i;
        if (!hresetn)
        begin
            hrdata <= 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend <= 1'b0;
            wr_idx <= 10'h000;
            state <= ST_IDLE;
            cmd_class <= `ELCS_CLASS_ALL;
            cursor <= `ELCS_RST_WORD;
            cur_valid <= 1'b0;
            scan_seq <= `ELCS_RST_WORD;
            copy_idx <= 7'h00;
            severity <= `ELCS_SEV_INVALID;
            int_status <= `ELCS_RST_INT;
            int_enable <= `ELCS_RST_INT;
            irq <= 1'b0;
            for (i = 0; i < 82; i = i + 1)
                text_area[i] <= 8'h00;
        end
        else
        begin
            hresp <= 1'b0;
            irq <= |(int_status & int_enable);
            // Address phase
            if (hready && hsel && htrans[1])
            begin
                wr_pend <= hwrite;
                wr_idx <= haddr[11:2];
                if (hwrite)
                begin
                    // Only command writes stall; every other transfer has no wait state
                    if ((haddr[11:2] >= `ELCS_IDX_ALL_CMD) && (haddr[11:2] <= `ELCS_IDX_AL_CMD))
                        hreadyout <= 1'b0;
                end
                else
                    hrdata <= next_rdata;
            end
            else
                wr_pend <= 1'b0;
            // Data phase of plain register writes
            if (wr_pend && (wr_idx == `ELCS_IDX_INT_ENABLE))
                int_enable <= hwdata[2:0];
            if (erase_s2)
                cur_valid <= 1'b0;
            // Command data phase; the bus stays stalled until the text area settles
            if (cmd_hit && (state == ST_IDLE))
            begin
                cmd_class <= cmd_off[1:0];
                if (cmd_reset)
                begin
                    scan_seq <= oldest;
                    state <= ST_SCAN;
                end
                else if (cmd_adv && cur_valid && !erase_s2)
                begin
                    scan_seq <= cur_lost ? oldest : cursor + 16'h0001;
                    state <= ST_SCAN;
                end
                else if (cmd_adv)
                begin
                    // Advance without a valid cursor finds nothing
                    severity <= `ELCS_SEV_INVALID;
                    for (i = 0; i < 82; i = i + 1)
                        text_area[i] <= 8'h00;
                    hreadyout <= 1'b1;
                end
                else
                    hreadyout <= 1'b1;
            end
            case (state)
                ST_IDLE:
                begin
                end
                ST_SCAN:
                begin
                    if (end_hit)
                    begin
                        cur_valid <= 1'b0;
                        severity <= `ELCS_SEV_INVALID;
                        for (i = 0; i < 82; i = i + 1)
                            text_area[i] <= 8'h00;
                        state <= ST_IDLE;
                        hreadyout <= 1'b1;
                    end
                    else if (class_match(scan_sev, cmd_class))
                    begin
                        cursor <= scan_seq;
                        cur_valid <= 1'b1;
                        severity <= {14'h0, scan_sev};
                        copy_idx <= 7'h00;
                        state <= ST_COPY;
                    end
                    else
                        scan_seq <= scan_seq + 16'h0001;
                end
                ST_COPY:
                begin
                    // Bytes past the stored length read as null
                    text_area[copy_idx] <= (copy_idx < cur_len) ?
                        text_mem[{cur_slot, copy_idx}] : 8'h00;
                    copy_idx <= copy_idx + 7'h01;
                    if (copy_idx == `ELCS_TEXT_LAST_BYTE)
                    begin
                        state <= ST_IDLE;
                        hreadyout <= 1'b1;
                    end
                end
                default:
                    state <= ST_IDLE;
            endcase
            // Sticky interrupt events; a new event wins over a clear
            int_status <= (int_status & ~((wr_pend && (wr_idx == `ELCS_IDX_INT_CLEAR)) ?
                hwdata[2:0] : 3'h0)) | {end_hit, erase_evt, commit && !erase_s2};
        end
    end

    // Read data multiplexer
    always @*
    begin
        next_rdata = 32'h0;
        txt_off = haddr[11:2] - `ELCS_IDX_TEXT_FIRST;
        case (haddr[11:2])
            `ELCS_IDX_ALL_COUNT: next_rdata = {16'h0, cnt_all};
            `ELCS_IDX_AW_COUNT: next_rdata = {16'h0, cnt_aw};
            `ELCS_IDX_AL_COUNT: next_rdata = {16'h0, cnt_al};
            `ELCS_IDX_SEVERITY: next_rdata = {16'h0, severity};
            `ELCS_IDX_SYS_STATUS1:
                next_rdata = HAS_SYS_CABINET ? {16'h0, sys_s2[15:0] & SYS_STATUS_MASK} : 32'h0;
            `ELCS_IDX_SYS_STATUS2:
                next_rdata = HAS_SYS_CABINET ? {16'h0, sys_s2[31:16] & SYS_STATUS_MASK} : 32'h0;
            `ELCS_IDX_SYS_STATUS3:
                next_rdata = HAS_SYS_CABINET ? {16'h0, sys_s2[47:32] & SYS_STATUS_MASK} : 32'h0;
            `ELCS_IDX_MOD_STATUS1: next_rdata = {16'h0, mod_s2[15:0] & MOD_STATUS_MASK};
            `ELCS_IDX_MOD_STATUS2: next_rdata = {16'h0, mod_s2[31:16] & MOD_STATUS_MASK};
            `ELCS_IDX_MOD_STATUS3: next_rdata = {16'h0, mod_s2[47:32] & MOD_STATUS_MASK};
            `ELCS_IDX_INT_STATUS: next_rdata = {29'h0, int_status};
            `ELCS_IDX_INT_ENABLE: next_rdata = {29'h0, int_enable};
            default:
            begin
                if ((haddr[11:2] >= `ELCS_IDX_TEXT_FIRST) && (haddr[11:2] <= `ELCS_IDX_TEXT_LAST))
                    next_rdata = {16'h0, text_area[{txt_off[5:0], 1'b0}],
                        text_area[{txt_off[5:0], 1'b1}]};
            end
        endcase
    end

endmodule // elcs_event_log
`default_nettype wire

// File: verilog/elcs_regs.vh
// Register indices, field values and limits of the event log cursor block
`ifndef ELCS_REGS_VH
`define ELCS_REGS_VH

// Register indices; the byte address is four times the index
`define ELCS_IDX_ALL_COUNT 10'h0fa
`define ELCS_IDX_AW_COUNT 10'h0fb
`define ELCS_IDX_AL_COUNT 10'h0fc
`define ELCS_IDX_ALL_CMD 10'h0fd
`define ELCS_IDX_AW_CMD 10'h0fe
`define ELCS_IDX_AL_CMD 10'h0ff
`define ELCS_IDX_TEXT_FIRST 10'h100
`define ELCS_IDX_TEXT_LAST 10'h128
`define ELCS_IDX_SEVERITY 10'h129
`define ELCS_IDX_SYS_STATUS1 10'h15e
`define ELCS_IDX_SYS_STATUS2 10'h15f
`define ELCS_IDX_SYS_STATUS3 10'h160
`define ELCS_IDX_MOD_STATUS1 10'h161
`define ELCS_IDX_MOD_STATUS2 10'h162
`define ELCS_IDX_MOD_STATUS3 10'h163
`define ELCS_IDX_INT_STATUS 10'h1f0
`define ELCS_IDX_INT_ENABLE 10'h1f1
`define ELCS_IDX_INT_CLEAR 10'h1f2

// Command values
`define ELCS_CMD_RESET 16'h0000
`define ELCS_CMD_ADVANCE 16'h0001

// Severity codes of stored events and of the severity register
`define ELCS_SEV_STATUS 2'h0
`define ELCS_SEV_NOTICE 2'h1
`define ELCS_SEV_ALARM 2'h2
`define ELCS_SEV_INVALID 16'hffff

// Command classes
`define ELCS_CLASS_ALL 2'h0
`define ELCS_CLASS_AW 2'h1
`define ELCS_CLASS_AL 2'h2

// Message text limits
`define ELCS_MSG_CHARS 7'h50
`define ELCS_TEXT_LAST_BYTE 7'h51

// Interrupt bits
`define ELCS_INT_STORED 0
`define ELCS_INT_ERASED 1
`define ELCS_INT_END 2

// Reset values
`define ELCS_RST_WORD 16'h0000
`define ELCS_RST_INT 3'h0

`endif

// File: testbench/elcs_event_log_props.sv
// Bus and interrupt checker bound to the event log cursor block
`timescale 1ns/1ns
`default_nettype none
module elcs_event_log_props #(
    parameter DEPTH_LOG2 = 12
) (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // Bus
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    // Interrupt
    input wire irq
);
    wire take = hsel & htrans[1] & hready;
    wire cmd = (haddr[11:2] >= 10'h0fd) && (haddr[11:2] <= 10'h0ff);
    logic [13:0] stall;
    // Length of the current command stall
    always @(posedge hclk or negedge hresetn)
        if (!hresetn)
            stall <= 14'h0;
        else
            stall <= hreadyout ? 14'h0 : stall + 14'h1;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    resp_okay_a: assert property (hresp == 1'b0)
        else $error("error response seen");
    read_nowait_a: assert property (take && !hwrite |=> hreadyout)
        else $error("read stalled");
    cmd_stall_a: assert property (take && hwrite && cmd |=> !hreadyout)
        else $error("command write not stalled");
    plain_write_a: assert property (take && hwrite && !cmd |=> hreadyout)
        else $error("plain write stalled");
    bad_cmd_a: assert property (take && hwrite && cmd ##1 hwdata[15:1] != 15'h0
        |-> ##[1:2] hreadyout)
        else $error("ignored command stalled too long");
    stall_bound_a: assert property (stall <= (14'h1 << DEPTH_LOG2) + 14'h5a)
        else $error("command stall too long");
    rdata_hold_a: assert property (!(take && !hwrite) |=> $stable(hrdata))
        else $error("read data changed without read");
    rdata_upper_a: assert property (hrdata[31:16] == 16'h0)
        else $error("upper read data not zero");
    irq_reset_a: assert property ($rose(hresetn) |-> !irq)
        else $error("interrupt high after reset");
    cover property (take && hwrite && cmd);
    cover property (stall > 14'h10);
    cover property ($rose(irq));
endmodule // elcs_event_log_props
bind elcs_event_log elcs_event_log_props #(.DEPTH_LOG2(DEPTH_LOG2)) elcs_event_log_props_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq));
`default_nettype wire

// File: testbench/elcs_host.sv
// Polling host model: single-word bus master
`timescale 1ns/1ns
`default_nettype none
module elcs_host (
    // Clock and answer
    input wire hclk,
    input wire hready,
    input wire [31:0] hrdata,
    // Request
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    initial
    begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end
    // One transfer; text is read word by word by the caller, one class at a time
    task xfer(input [9:0] i, input w, input [31:0] d, output [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {20'h0, i, 2'h0};
        htrans <= 2'h2;
        hwrite <= w;
        hwdata <= ~hwdata;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
    endtask
endmodule // elcs_host
`default_nettype wire

// File: testbench/elcs_event_log_tb.sv
// Self-checking bench of the event log cursor block
`timescale 1ns/1ns
`default_nettype none
module elcs_event_log_tb;
    logic hclk, hresetn, hsel, hwrite, hresp, irq, ev_v, ev_l, erase;
    wire hready;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0] htrans, ev_s;
    logic [2:0] hsize;
    logic [7:0] ev_b;
    logic [47:0] sys, mods;
    int mismatches, compares;
    logic [9:0] ri [11] = '{10'h0fd, 10'h0fd, 10'h0fd, 10'h0fd, 10'h0ff, 10'h0fd,
        10'h0fe, 10'h0fe, 10'h0ff, 10'h0ff, 10'h0ff};
    logic [15:0] rw [11] = '{0, 1, 1, 1, 0, 1, 0, 1, 1, 0, 2};
    logic [31:0] rs [11] = '{0, 2, 1, 'hffff, 2, 1, 2, 1, 'hffff, 2, 2};
    logic [31:0] r0 [11] = '{'h4142, 'h4344, 'h4600, 0, 'h4344, 'h4600, 'h4344, 'h4600,
        0, 'h4344, 'h4344};
    elcs_host host_i (.hclk(hclk), .hready(hready), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    elcs_event_log #(.DEPTH_LOG2(4)) elcs_event_log_i (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
        .hresp(hresp), .evt_byte_valid(ev_v), .evt_byte(ev_b), .evt_last(ev_l),
        .evt_severity(ev_s), .log_erase_pin(erase), .sys_status_pins(sys),
        .mod_status_pins(mods), .irq(irq));
    task chk(input string n, input [31:0] s, input [31:0] e);
        compares++;
        if (s !== e)
        begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task wr(input [9:0] i, input [15:0] d);
        host_i.xfer(i, 1'b1, {16'h0, d}, q);
    endtask
    task rc(input string n, input [9:0] i, input [31:0] e);
        host_i.xfer(i, 1'b0, 32'h0, q);
        chk(n, q, e);
    endtask
    task ev(input [1:0] s, input int n, input [7:0] b);
        for (int k = 0; k < n; k++)
        begin
            @(posedge hclk);
            ev_v <= 1'b1;
            ev_b <= b + k[7:0];
            ev_l <= (k == n - 1);
            ev_s <= s;
        end
        @(posedge hclk);
        ev_v <= 1'b0;
        ev_l <= 1'b0;
    endtask
    task end_sim;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    initial
    begin
        #200000;
        mismatches++;
        end_sim;
    end
    initial
    begin
        {hresetn, ev_v, ev_l, erase, ev_s, ev_b} = 0;
        sys = 48'h3333_2222_1111;
        mods = 48'h6666_5555_4444;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        rc("severity", 10'h129, 32'hffff);
        rc("count", 10'h0fa, 32'h0);
        rc("unmapped", 10'h0f0, 32'h0);
        rc("text", 10'h100, 32'h0);
        $display("reset test done");
        ev(0, 2, 8'h41);
        ev(2, 3, 8'h43);
        ev(1, 1, 8'h46);
        for (int i = 0; i < 3; i++)
            rc("count", 10'h0fa + i[9:0], 32'h3 - i);
        wr(10'h0fa, 16'h5);
        rc("count", 10'h0fa, 32'h3);
        for (int i = 0; i < 11; i++)
        begin
            wr(ri[i], rw[i]);
            rc("severity", 10'h129, rs[i]);
            rc("text", 10'h100, r0[i]);
            rc("text", 10'h101, (r0[i] == 'h4344) ? 32'h4500 : 32'h0);
            $display("row %0d done", i);
        end
        for (int k = 0; k < 6; k++)
            rc("status", 10'h15e + k[9:0], 32'h1111 * (k + 1));
        wr(10'h1f2, 16'h7);
        rc("int status", 10'h1f0, 32'h0);
        wr(10'h1f1, 16'h1);
        ev(0, 1, 8'h47);
        rc("int status", 10'h1f0, 32'h1);
        chk("irq", {31'h0, irq}, 32'h1);
        rc("text", 10'h100, 32'h4344);
        wr(10'h1f1, 16'h0);
        repeat (2) @(posedge hclk);
        chk("irq", {31'h0, irq}, 32'h0);
        wr(10'h1f2, 16'h1);
        rc("int status", 10'h1f0, 32'h0);
        $display("interrupt test done");
        ev(0, 85, 8'h01);
        wr(10'h0fd, 16'h0);
        repeat (4) wr(10'h0fd, 16'h1);
        rc("text", 10'h127, 32'h4f50);
        rc("text", 10'h128, 32'h0);
        @(posedge hclk);
        erase <= 1'b1;
        repeat (6) @(posedge hclk);
        erase <= 1'b0;
        repeat (6) @(posedge hclk);
        wr(10'h0fd, 16'h1);
        rc("severity", 10'h129, 32'hffff);
        wr(10'h0fd, 16'h0);
        rc("severity", 10'h129, 32'hffff);
        rc("text", 10'h100, 32'h0);
        for (int j = 0; j < 17; j++)
            ev(0, 1, 8'h30 + j[7:0]);
        rc("count", 10'h0fa, 32'h10);
        wr(10'h0fd, 16'h0);
        rc("text", 10'h100, 32'h3100);
        $display("long text, erase and wrap tests done");
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rc("severity", 10'h129, 32'hffff);
        rc("count", 10'h0fa, 32'h0);
        rc("text", 10'h100, 32'h0);
        wr(10'h0fd, 16'h1);
        rc("severity", 10'h129, 32'hffff);
        rc("text", 10'h100, 32'h0);
        $display("mid-run reset test done");
        end_sim;
    end
endmodule // elcs_event_log_tb
`default_nettype wire
